// ===== hw/host_port_cfg.svh
// Timing counts, strap bit positions and lane widths of the host register port
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// ----------------------------------------------------------------
// Bus and lane widths
// ----------------------------------------------------------------
`define HP_BUS_W 32
`define HP_LANE_W 8
`define HP_UPPER_W 24

// ----------------------------------------------------------------
// Strap bit positions of host_port_mode_select
// ----------------------------------------------------------------
`define HP_MODE_POL_BIT 0
`define HP_MODE_VAR_BIT 1

// ----------------------------------------------------------------
// Timing counts in core_clk cycles
// ----------------------------------------------------------------
`define HP_ACCESS_CLKS 5
`define HP_DATA_SAMPLE_CLK 4
`define HP_GAP_CLKS 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HP_LANE_RST 8'h00
`define HP_CNT_RST 3'h0

`endif

// ===== hw/host_port_pkg.sv
// Sequencer state types of the two ends of the host register port
package host_port_pkg;

  // ----------------------------------------------------------------
  // Device end sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    DEV_IDLE,
    DEV_ACCESS
  } dev_state_t;

  // ----------------------------------------------------------------
  // Host end sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_ACCESS,
    HOST_GAP
  } host_state_t;

endpackage

// ===== hw/host_port_if.sv
// Pin bundle between the host processor end and the device end
`timescale 1ns/1ps
`include "host_port_cfg.svh"

interface host_port_if #(
  parameter int ADDR_W = 8
);
  // Host-driven pins
  logic chipSelectN;
  logic dirPin;
  logic [ADDR_W-1:0] regAddrLines;
  logic [1:0] hostPortModeSelect;
  logic [`HP_BUS_W-1:0] hostDataOut;
  logic hostDataOe;
  // Device-driven pins
  logic [`HP_LANE_W-1:0] devLaneOut;
  logic devLaneOe;
  logic accessDoneNOut;
  logic accessDoneNOe;
  // Resolved wires
  wire [`HP_BUS_W-1:0] hostDataBus;
  wire accessDoneN;

  // Low byte is the shared register data lane
  // Nobody driving: the lane reads high through its board pull-ups
  assign hostDataBus[`HP_LANE_W-1:0] = devLaneOe ? devLaneOut :
                                       (hostDataOe ? hostDataOut[`HP_LANE_W-1:0] : 8'hff);
  // Upper bytes are never driven by the device; the host drives them to zero during writes, otherwise board pull-ups hold them high
  assign hostDataBus[`HP_BUS_W-1:`HP_LANE_W] = hostDataOe ?
                                               hostDataOut[`HP_BUS_W-1:`HP_LANE_W] :
                                               24'hffffff;
  // Done line reads high through its pull-up when the device lets go of it
  assign accessDoneN = accessDoneNOe ? accessDoneNOut : 1'b1;

  modport dev (
    input chipSelectN, dirPin, regAddrLines, hostPortModeSelect, hostDataBus,
    output devLaneOut, devLaneOe, accessDoneNOut, accessDoneNOe
  );

  modport host (
    input hostDataBus, accessDoneN,
    output chipSelectN, dirPin, regAddrLines, hostPortModeSelect, hostDataOut, hostDataOe
  );
endinterface

// ===== hw/host_port_device.sv
// Device end of the 8-bit host register port: decodes host cycles into register strobes
//
// How it works
// R1 - Register transfers use only the low byte lane
// R2 - Device never drives upper 24 bus bits
// R3 - Mode bit 0 selects write-enable polarity
// R4 - Variable mode: read data valid in clock five
// R5 - Variable mode: keep driving while select stays low
// R6 - Variable mode: select high releases lane, forces done high
// R7 - Variable mode: host keeps select high two clocks between accesses
// R8 - Variable mode: done line always driven
// R9 - Fixed mode: five clocks, lane driven clock five
// R10 - Fixed mode: done high four, low fifth
// R11 - Host drives write data clock after select
// R12 - Fixed mode accesses may run back to back
// R13 - Address and direction captured at select sample
`timescale 1ns/1ps
`include "host_port_cfg.svh"

module host_port_device #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host-facing pins
  host_port_if.dev hp,
  // Register file side
  output logic [ADDR_W-1:0] regAddr,
  output logic regWrStrobe,
  output logic [`HP_LANE_W-1:0] regWrData,
  output logic regRdStrobe,
  input wire logic [`HP_LANE_W-1:0] regRdData,
  output logic accessBusy
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Address must have at least one line
  if (ADDR_W < 1) begin : g_bad_addr
    $error("host_port_device: ADDR_W must be at least 1");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [2:0] LastClk = 3'(`HP_ACCESS_CLKS);   // Clock that returns data
  localparam logic [2:0] SampleClk = 3'(`HP_DATA_SAMPLE_CLK); // Clock ending at the data edge

  // Strap synchroniser, straps are board pins
  logic [1:0] modeMetaFf;
  logic [1:0] modeSyncFf;

  // Sequencer state
  host_port_pkg::dev_state_t stateFf, nxtState;
  logic [2:0] cntFf, nxtCnt;              // Clock number within access, 1..5
  logic [ADDR_W-1:0] addrFf, nxtAddr;     // Captured address
  logic isWriteFf, nxtIsWrite;            // Captured direction
  logic varFf, nxtVar;                    // Variable-length mode for this access
  logic [`HP_LANE_W-1:0] rdDataFf, nxtRdData;
  logic [`HP_LANE_W-1:0] wrDataFf, nxtWrData;
  logic wrStrobeFf, nxtWrStrobe;
  logic rdStrobeFf, nxtRdStrobe;
  logic laneOeFf, nxtLaneOe;              // Lane drive, before async release
  logic readyFf, nxtReady;                // Done level, before async force
  logic readyOeFf, nxtReadyOe;
  logic busyFf, nxtBusy;
  logic startAcc;                         // Select sampled low while free
  logic selReleased;                      // Select high in variable mode

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  // Plain two-stage; only the second stage feeds logic
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      modeMetaFf <= 2'h0;
      modeSyncFf <= 2'h0;
    end else begin
      modeMetaFf <= hp.hostPortModeSelect;
      modeSyncFf <= modeMetaFf;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Access counter runs clock 1 to 5 from the edge that sees select low
  always_comb begin
    nxtState = stateFf;
    nxtCnt = cntFf;
    nxtAddr = addrFf;
    nxtIsWrite = isWriteFf;
    nxtVar = varFf;
    nxtRdData = rdDataFf;
    nxtWrData = wrDataFf;
    nxtWrStrobe = 1'b0;
    nxtRdStrobe = 1'b0;
    startAcc = 1'b0;
    case (stateFf)
      host_port_pkg::DEV_IDLE: begin
        // Track the strap while idle so the done line mode is current
        nxtVar = modeSyncFf[`HP_MODE_VAR_BIT];
        startAcc = !hp.chipSelectN;
      end
      host_port_pkg::DEV_ACCESS: begin
        if (varFf && hp.chipSelectN) begin
          // Select ended: close the access, aborting if it was short
          nxtState = host_port_pkg::DEV_IDLE; // R6
        end else if (cntFf != LastClk) begin
          nxtCnt = cntFf + 3'h1;
          if (cntFf == SampleClk) begin
            if (isWriteFf) begin
              // Host data has stood since clock 1, take it here
              nxtWrStrobe = 1'b1; // R11
              nxtWrData = hp.hostDataBus[`HP_LANE_W-1:0]; // R1
            end else begin
              // Register file had clocks 1 to 4 to answer
              nxtRdData = regRdData;
            end
          end
        end else if (!varFf) begin
          // Fixed length ends after clock 5; a new select may follow at once
          nxtState = host_port_pkg::DEV_IDLE; // R9
          startAcc = !hp.chipSelectN; // R12
        end
        // Variable mode holds clock 5 while select stays low
      end
      default: begin
        nxtState = host_port_pkg::DEV_IDLE;
      end
    endcase
    if (startAcc) begin
      // Address and direction are held for the whole access
      nxtState = host_port_pkg::DEV_ACCESS;
      nxtCnt = 3'h1;
      nxtAddr = hp.regAddrLines; // R13
      nxtIsWrite = hp.dirPin ^ modeSyncFf[`HP_MODE_POL_BIT]; // R3
      nxtVar = modeSyncFf[`HP_MODE_VAR_BIT];
      nxtRdStrobe = hp.dirPin == modeSyncFf[`HP_MODE_POL_BIT];
    end
    // Pin drive follows the next state
    nxtLaneOe = nxtState == host_port_pkg::DEV_ACCESS && nxtCnt == LastClk && !nxtIsWrite; // R4
    nxtReady = !(nxtState == host_port_pkg::DEV_ACCESS && nxtCnt == LastClk); // R10
    nxtReadyOe = nxtVar || nxtState == host_port_pkg::DEV_ACCESS; // R8
    nxtBusy = nxtState == host_port_pkg::DEV_ACCESS;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stateFf <= host_port_pkg::DEV_IDLE;
      cntFf <= `HP_CNT_RST;
      addrFf <= '0;
      isWriteFf <= 1'b0;
      varFf <= 1'b0;
      rdDataFf <= `HP_LANE_RST;
      wrDataFf <= `HP_LANE_RST;
      wrStrobeFf <= 1'b0;
      rdStrobeFf <= 1'b0;
      laneOeFf <= 1'b0;
      readyFf <= 1'b1;
      readyOeFf <= 1'b0;
      busyFf <= 1'b0;
    end else begin
      stateFf <= nxtState;
      cntFf <= nxtCnt;
      addrFf <= nxtAddr;
      isWriteFf <= nxtIsWrite;
      varFf <= nxtVar;
      rdDataFf <= nxtRdData;
      wrDataFf <= nxtWrData;
      wrStrobeFf <= nxtWrStrobe;
      rdStrobeFf <= nxtRdStrobe;
      laneOeFf <= nxtLaneOe;
      readyFf <= nxtReady;
      readyOeFf <= nxtReadyOe;
      busyFf <= nxtBusy;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Release must not wait for an edge, so select gates the registered
  // lane enable and done level directly; this is the only path from a pin to a pin
  assign selReleased = varFf && hp.chipSelectN;

  // Read data held for as long as select stays low
  assign hp.devLaneOut = rdDataFf; // R2 R5
  assign hp.devLaneOe = laneOeFf && !selReleased; // R6
  assign hp.accessDoneNOut = readyFf || selReleased; // R6
  assign hp.accessDoneNOe = readyOeFf; // R10

  // ----------------------------------------------------------------
  // Register file side
  // ----------------------------------------------------------------
  assign regAddr = addrFf;
  assign regWrStrobe = wrStrobeFf;
  assign regWrData = wrDataFf;
  assign regRdStrobe = rdStrobeFf;
  assign accessBusy = busyFf;

endmodule

// ===== hw/host_port_host.sv
// Host processor end of the 8-bit register port: turns requests into pin cycles
`timescale 1ns/1ps
`include "host_port_cfg.svh"

module host_port_host #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pins toward the device
  host_port_if.host hp,
  // Board straps
  input wire logic [1:0] modeStrap,
  // Request side
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [`HP_LANE_W-1:0] reqWData,
  output logic reqReady,
  // Answer side
  output logic rspValid,
  output logic [`HP_LANE_W-1:0] rspData
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 1) begin : g_bad_addr
    $error("host_port_host: ADDR_W must be at least 1");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [2:0] LastClk = 3'(`HP_ACCESS_CLKS);
  localparam logic [2:0] HoldClk = 3'(`HP_ACCESS_CLKS + 1); // Variable mode: one clock of hold
  localparam logic [2:0] PreLastClk = 3'(`HP_ACCESS_CLKS - 1);
  localparam logic [2:0] GapLast = 3'(`HP_GAP_CLKS - 1);

  host_port_pkg::host_state_t stateFf, nxtState;
  logic [1:0] modeMetaFf;                 // First strap flop, read only by modeFf
  logic [1:0] modeFf;                     // Straps, assumed static
  logic [2:0] cntFf, nxtCnt;              // Device clock number 1..5, then 6 in the variable-mode hold; also counts the gap
  logic csnFf, nxtCsn;
  logic dirFf, nxtDir;
  logic [ADDR_W-1:0] addrFf, nxtAddr;
  logic curWriteFf, nxtCurWrite;          // Direction of the access in flight
  logic [`HP_LANE_W-1:0] wDataFf, nxtWData;
  logic wOeFf, nxtWOe;
  logic pendFf, nxtPend;                  // Next fixed access already selected
  logic pendWriteFf, nxtPendWrite;
  logic [`HP_LANE_W-1:0] pendDataFf, nxtPendData;
  logic readyFf, nxtReqReady;
  logic rspValidFf, nxtRspValid;
  logic [`HP_LANE_W-1:0] rspDataFf, nxtRspData;
  logic take;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxtState = stateFf;
    nxtCnt = cntFf;
    nxtCsn = csnFf;
    nxtDir = dirFf;
    nxtAddr = addrFf;
    nxtCurWrite = curWriteFf;
    nxtWData = wDataFf;
    nxtWOe = wOeFf;
    nxtPend = pendFf;
    nxtPendWrite = pendWriteFf;
    nxtPendData = pendDataFf;
    nxtRspValid = 1'b0;
    nxtRspData = rspDataFf;
    take = reqValid && readyFf;
    case (stateFf)
      host_port_pkg::HOST_IDLE: begin
        if (take) begin
          // Select goes low; the device samples it at the next edge
          nxtState = host_port_pkg::HOST_ACCESS;
          nxtCnt = `HP_CNT_RST;
          nxtCsn = 1'b0;
          nxtAddr = reqAddr;
          nxtDir = reqWrite ^ modeFf[`HP_MODE_POL_BIT]; // R3
          nxtCurWrite = reqWrite;
          nxtWData = reqWData;
        end
      end
      host_port_pkg::HOST_ACCESS: begin
        if (cntFf == `HP_CNT_RST) begin
          // Write data from the clock after select is sampled
          nxtWOe = curWriteFf; // R11
          // Fixed mode raises select after one clock; variable keeps it low
          nxtCsn = !modeFf[`HP_MODE_VAR_BIT]; // R4
          nxtCnt = 3'h1;
        end else if (modeFf[`HP_MODE_VAR_BIT]) begin
          if (cntFf != HoldClk) begin
            nxtCnt = cntFf + 3'h1;
          end
          if (hp.accessDoneN == 1'b0 && cntFf == HoldClk) begin
            // Select stays low one clock past the data clock, so the lane hold is used
            // R5
            nxtRspValid = !curWriteFf; // R4
            nxtRspData = hp.hostDataBus[`HP_LANE_W-1:0];
            nxtCsn = 1'b1;
            nxtWOe = 1'b0;
            nxtCnt = 3'h1;
            nxtState = host_port_pkg::HOST_GAP; // R7
          end
        end else if (cntFf != LastClk) begin
          nxtCnt = cntFf + 3'h1;
          if (cntFf == PreLastClk && take) begin
            // Select the next access during clock 5 of this one
            nxtPend = 1'b1; // R12
            nxtCsn = 1'b0;
            nxtAddr = reqAddr;
            nxtDir = reqWrite ^ modeFf[`HP_MODE_POL_BIT];
            nxtPendWrite = reqWrite;
            nxtPendData = reqWData;
          end
        end else begin
          // Fixed length: data stands on the lane in clock 5
          nxtRspValid = !curWriteFf; // R9
          nxtRspData = hp.hostDataBus[`HP_LANE_W-1:0];
          nxtWOe = 1'b0;
          nxtState = host_port_pkg::HOST_IDLE;
          if (pendFf) begin
            nxtState = host_port_pkg::HOST_ACCESS;
            nxtPend = 1'b0;
            nxtCsn = 1'b1;
            nxtCnt = 3'h1;
            nxtCurWrite = pendWriteFf;
            nxtWData = pendDataFf;
            nxtWOe = pendWriteFf;
          end
        end
      end
      host_port_pkg::HOST_GAP: begin
        // Select stays high for the minimum gap
        if (cntFf >= GapLast) begin
          nxtState = host_port_pkg::HOST_IDLE;
        end else begin
          nxtCnt = cntFf + 3'h1;
        end
      end
      default: begin
        nxtState = host_port_pkg::HOST_IDLE;
      end
    endcase
    nxtReqReady = nxtState == host_port_pkg::HOST_IDLE ||
                  (nxtState == host_port_pkg::HOST_ACCESS && !modeFf[`HP_MODE_VAR_BIT] &&
                   nxtCnt == PreLastClk && !nxtPend);
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stateFf <= host_port_pkg::HOST_IDLE;
      modeMetaFf <= 2'h0;
      modeFf <= 2'h0;
      cntFf <= `HP_CNT_RST;
      csnFf <= 1'b1;
      dirFf <= 1'b0;
      addrFf <= '0;
      curWriteFf <= 1'b0;
      wDataFf <= `HP_LANE_RST;
      wOeFf <= 1'b0;
      pendFf <= 1'b0;
      pendWriteFf <= 1'b0;
      pendDataFf <= `HP_LANE_RST;
      readyFf <= 1'b0;
      rspValidFf <= 1'b0;
      rspDataFf <= `HP_LANE_RST;
    end else begin
      stateFf <= nxtState;
      modeMetaFf <= modeStrap;
      modeFf <= modeMetaFf;
      cntFf <= nxtCnt;
      csnFf <= nxtCsn;
      dirFf <= nxtDir;
      addrFf <= nxtAddr;
      curWriteFf <= nxtCurWrite;
      wDataFf <= nxtWData;
      wOeFf <= nxtWOe;
      pendFf <= nxtPend;
      pendWriteFf <= nxtPendWrite;
      pendDataFf <= nxtPendData;
      readyFf <= nxtReqReady;
      rspValidFf <= nxtRspValid;
      rspDataFf <= nxtRspData;
    end
  end

  // ----------------------------------------------------------------
  // Pins and user outputs
  // ----------------------------------------------------------------
  assign hp.chipSelectN = csnFf;
  assign hp.dirPin = dirFf;
  assign hp.regAddrLines = addrFf;
  assign hp.hostPortModeSelect = modeFf;
  assign hp.hostDataOut = {24'h000000, wDataFf}; // R1
  assign hp.hostDataOe = wOeFf;
  assign reqReady = readyFf;
  assign rspValid = rspValidFf;
  assign rspData = rspDataFf;

endmodule

// ===== test/host_port_asserts.sv
// Pin-level checker for the link between host and device ends of the register port
`timescale 1ns/1ps
`include "host_port_cfg.svh"

module host_port_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host-driven pins
  input wire logic chipSelectN,
  input wire logic dirPin,
  input wire logic [1:0] hostPortModeSelect,
  input wire logic hostDataOe,
  // Device-driven pins
  input wire logic devLaneOe,
  input wire logic accessDoneNOut,
  input wire logic accessDoneNOe,
  // Resolved bus
  input wire logic [`HP_BUS_W-1:0] hostDataBus
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic varMode; // Variable-length cycles selected
  logic isWrite; // Direction pin decoded through polarity strap
  logic [2:0] settleCnt_ff; // Cycles since reset or strap change
  logic [2:0] nxt_settleCnt;
  logic [1:0] modePrev_ff; // Straps seen last cycle
  logic [1:0] nxt_modePrev;

  assign varMode = hostPortModeSelect[`HP_MODE_VAR_BIT];
  assign isWrite = dirPin ^ hostPortModeSelect[`HP_MODE_POL_BIT];

  // Device syncs straps, so give it a few clocks before judging the done line
  always_comb begin
    nxt_modePrev = hostPortModeSelect;
    nxt_settleCnt = settleCnt_ff;
    if (!rst_n || hostPortModeSelect != modePrev_ff) begin
      nxt_settleCnt = 3'h0;
    end else if (settleCnt_ff != 3'h7) begin
      nxt_settleCnt = settleCnt_ff + 3'h1;
    end
  end

  // Registers only
  always_ff @(posedge core_clk) begin
    settleCnt_ff <= nxt_settleCnt;
    modePrev_ff <= nxt_modePrev;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_fixed_done_shape: assert property (!varMode && $rose(accessDoneNOe) |->
    (accessDoneNOe && accessDoneNOut) [*4] ##1 (accessDoneNOe && !accessDoneNOut))
    else $error("done line shape wrong in fixed cycle");
  a_fixed_done_release: assert property (!varMode && accessDoneNOe && !accessDoneNOut |=>
    !accessDoneNOe || accessDoneNOut)
    else $error("done line not released after fifth clock");
  a_fixed_lane_fifth: assert property (!varMode && devLaneOe |->
    accessDoneNOe && !accessDoneNOut)
    else $error("lane driven outside fifth clock");
  a_fixed_lane_once: assert property (!varMode && devLaneOe |=> !devLaneOe)
    else $error("lane driven longer than one clock");
  a_fixed_write_data: assert property (!varMode && !chipSelectN && isWrite |=>
    hostDataOe [*5])
    else $error("write data not held from clock after select");
  a_var_five_clocks: assert property (varMode && $fell(chipSelectN) |=>
    accessDoneNOut [*4] ##1 (!accessDoneNOut && !chipSelectN))
    else $error("variable access done not in fifth clock");
  a_var_read_lane: assert property (varMode && $fell(chipSelectN) && !isWrite |->
    ##5 devLaneOe)
    else $error("variable read data missing in fifth clock");
  a_var_hold_lane: assert property (varMode && $past(devLaneOe) && !chipSelectN |->
    devLaneOe)
    else $error("lane dropped while select held");
  a_var_release: assert property (varMode && settleCnt_ff == 3'h7 && chipSelectN |->
    !devLaneOe && accessDoneNOut)
    else $error("select high did not release lane and done");
  a_var_done_driven: assert property (varMode && settleCnt_ff == 3'h7 |->
    accessDoneNOe)
    else $error("done line floated in variable mode");
  a_var_select_gap: assert property (varMode && $rose(chipSelectN) |=> chipSelectN)
    else $error("select gap shorter than two clocks");
  a_upper_undriven: assert property (devLaneOe |->
    !hostDataOe && hostDataBus[31:8] == 24'hffffff)
    else $error("upper bus driven during register read");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_fixed_read: cover property (!varMode && devLaneOe);
  c_var_read: cover property (varMode && devLaneOe);
  c_back_to_back: cover property (!varMode && accessDoneNOe && !accessDoneNOut
    ##1 accessDoneNOe && accessDoneNOut);
endmodule

// ===== test/tb_host_register_access_port.sv
// Self-checking bench joining the host and device ends of the register port
`timescale 1ns/1ps
`include "host_port_cfg.svh"

module tb_host_register_access_port;
  // Clock, reset, bookkeeping
  logic core_clk;
  logic rst_n;
  int errors;
  int total_checks;
  int cyc; // Counts rising edges for spacing checks
  int takeCyc; // Edge count at last accepted request
  int rdStrobes; // Read strobes seen at the register file
  // Host request side
  logic [1:0] modeStrap;
  logic reqValid;
  logic reqWrite;
  logic [7:0] reqAddr;
  logic [`HP_LANE_W-1:0] reqWData;
  logic reqReady;
  logic rspValid;
  logic [`HP_LANE_W-1:0] rspData;
  // Device register side
  logic [7:0] regAddr;
  logic regWrStrobe;
  logic [`HP_LANE_W-1:0] regWrData;
  logic regRdStrobe;
  logic accessBusy;
  logic [`HP_LANE_W-1:0] regFile [256]; // Simple register file behind the device
  logic [`HP_LANE_W-1:0] rdVal;

  // ----------------------------------------------------------------
  // Ends, pins and checker
  // ----------------------------------------------------------------
  host_port_if u_host_port_if ();

  host_port_host u_host_port_host (
    .core_clk(core_clk), .rst_n(rst_n), .hp(u_host_port_if), .modeStrap(modeStrap),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWData(reqWData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));

  host_port_device u_host_port_device (
    .core_clk(core_clk), .rst_n(rst_n), .hp(u_host_port_if), .regAddr(regAddr),
    .regWrStrobe(regWrStrobe), .regWrData(regWrData), .regRdStrobe(regRdStrobe),
    .regRdData(regFile[regAddr]), .accessBusy(accessBusy));

  host_port_asserts u_host_port_asserts (
    .core_clk(core_clk), .rst_n(rst_n),
    .chipSelectN(u_host_port_if.chipSelectN), .dirPin(u_host_port_if.dirPin),
    .hostPortModeSelect(u_host_port_if.hostPortModeSelect),
    .hostDataOe(u_host_port_if.hostDataOe), .devLaneOe(u_host_port_if.devLaneOe),
    .accessDoneNOut(u_host_port_if.accessDoneNOut),
    .accessDoneNOe(u_host_port_if.accessDoneNOe),
    .hostDataBus(u_host_port_if.hostDataBus));

  // ----------------------------------------------------------------
  // Clock and register file
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Writes land on the strobe edge; reads are combinational from regAddr
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (regRdStrobe === 1'b1) begin
      rdStrobes <= rdStrobes + 1;
    end
    if (regWrStrobe === 1'b1) begin
      regFile[regAddr] <= regWrData;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count; four-state so an unknown never matches
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Final verdict, also reached when a wait runs out
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Bounds every handshake wait so a hung end cannot stall the run
  task automatic guard(inout int n);
    n++;
    if (n > 50) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      wrap_up();
    end
  endtask

  // Present one request at a falling edge and hold it until taken
  task automatic send(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqWData = d;
    while (reqReady !== 1'b1) begin
      @(negedge core_clk);
      guard(n);
    end
    @(posedge core_clk);
    @(negedge core_clk);
    takeCyc = cyc;
  endtask

  // Read request; valid dropped after take so no second read is issued
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    int n;
    n = 0;
    send(1'b0, a, 8'h00);
    reqValid = 1'b0;
    while (rspValid !== 1'b1) begin
      @(negedge core_clk);
      guard(n);
    end
    v = rspData;
  endtask

  // ----------------------------------------------------------------
  // Main sequence: every strap setting, back-to-back writes in fixed mode, readback
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] d1;
    logic [7:0] d2;
    int t0;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    takeCyc = 0;
    rdStrobes = 0;
    rst_n = 1'b0;
    modeStrap = 2'h0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 8'h00;
    reqWData = 8'h00;
    foreach (regFile[i]) regFile[i] = 8'h00;
    for (int m = 0; m < 4; m++) begin
      // Straps change only under reset, so the device never sees them move mid-access
      @(negedge core_clk);
      rst_n = 1'b0;
      modeStrap = m[1:0];
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      // Straps pass two flops in each end before the done line follows them
      repeat (5) @(negedge core_clk);
      check(u_host_port_if.accessDoneNOe, m[1]);
      check(accessBusy, 1'b0);
      a1 = 8'h00 + m[7:0];
      a2 = 8'hff - m[7:0];
      d1 = 8'ha5 ^ m[7:0];
      d2 = 8'h3c + m[7:0];
      send(1'b1, a1, d1);
      t0 = takeCyc;
      send(1'b1, a2, d2);
      if (!m[1]) begin
        check(takeCyc - t0, 5);
      end
      read_reg(a1, rdVal);
      check(rdVal, d1);
      read_reg(a2, rdVal);
      check(rdVal, d2);
      check(regFile[a1], d1);
      check(regFile[a2], d2);
    end
    check(rdStrobes, 8);
    wrap_up();
  end
endmodule
